/* File: verilog/bgc_pkg.sv */
/*
  Shared constants and types for the buck gate control and protection block:
  timing figures, trip percentages, register offsets, state codes, carriers.
  Assumes a 50 MHz system clock and a 32-bit word register port.
*/
package bgc_pkg;

  // System clock
  localparam int CLK_NS = 20;

  // Gate interlock gap, least time, so rounded up
  localparam int DEAD_NS  = 20;
  localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;

  // Overcurrent blanking after high-side turn-on
  localparam int BLANK_NS  = 300;
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;

  // Soft start length in switching cycles
  localparam int SS_CYCLES = 2048;

  // Trip windows in percent of the programmed reference
  localparam int PCT_FULL     = 100;
  localparam int WIN_FAST_PCT = 5;
  localparam int WIN_GOOD_PCT = 10;
  localparam int OVP_PCT      = 115;

  // Voltage code: all pins released reads as all ones
  localparam logic [4:0]  CODE_RELEASED = 5'h1f;
  // Reference code = base + step * voltage code (scale of the sense converter)
  localparam logic [11:0] REF_BASE      = 12'h200;
  localparam logic [11:0] REF_STEP      = 12'h020;

  // Register offsets (byte addresses)
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_INT_STAT = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h8;
  localparam logic [3:0] ADDR_CTRL     = 4'hc;

  // Control register
  localparam int   CTRL_FAST_EN  = 0;
  localparam logic CTRL_FAST_RST = 1'b1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SOFT = 4'h2,
    ST_RUN  = 4'h4,
    ST_OVP  = 4'h8
  } bgc_state_t;

  // Gate command pair
  typedef struct packed {
    logic hs;
    logic ls;
  } bgc_gate_t;

  // Interrupt events, bit 0 first from the bottom
  typedef struct packed {
    logic pgLost;
    logic fast;
    logic ocp;
    logic overvoltage_shutdown;
  } bgc_event_t;

endpackage : bgc_pkg

/* File: verilog/bgc_deadtime.sv */
/*
  Interlocked gate pair with a fixed dead gap between the two switches.
  Assumes a registered high-side demand on ref_clk; enable low parks both off.
*/
`timescale 1ns/1ps
module bgc_deadtime #(
  parameter int DEAD = bgc_pkg::DEAD_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              enable,
  input  wire logic              hsDemand,
  output bgc_pkg::bgc_gate_t     gate
);

  localparam logic [3:0] DEAD_LAST = 4'(DEAD - 1);

  logic [3:0] offCnt_r;
  wire        wantHs  = enable & hsDemand;
  wire        wantLs  = enable & ~hsDemand;
  wire        bothOff = ~gate.hs & ~gate.ls;
  wire        gapDone = bothOff & (offCnt_r >= DEAD_LAST);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      offCnt_r <= 4'h0;
    end else if (!bothOff) begin
      offCnt_r <= 4'h0;
    end else if (offCnt_r != DEAD_LAST) begin
      offCnt_r <= offCnt_r + 4'h1;
    end
  end

  // Turn-off is immediate, turn-on waits for the gap
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate <= '0;
    end else begin
      gate.hs <= gate.hs ? wantHs : (wantHs & gapDone); // RL1
      gate.ls <= gate.ls ? wantLs : (wantLs & gapDone); // RL1
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  no_overlap_a: assert property (!(gate.hs && gate.ls)) // RL1
    else $error("both gates on");

  dead_gap_a: assert property ($rose(gate.hs) |-> $past(!gate.ls)) // RL1
    else $error("high side on without gap");

endmodule : bgc_deadtime

/* File: verilog/bgc_ctrl.sv */
/*
  Buck gate control and protection: ramp PWM, soft start, fast transient
  overrides, output-ok flag, latched overvoltage shutdown, cycle-by-cycle
  current limit, register port with interrupt.
  Assumes senseCode and errAmpCode come from converters on ref_clk; the
  enable, voltage code and current limit comparator are asynchronous pins.
*/
// Our own choices: strobed register access and the address map.
// Behaviour
// RL1: Never turn one gate on before the other is off; 20 ns gap.
// RL2: Pulses come from error level compared with internal ramp.
// RL3: Flag fast excursion when output leaves plus or minus 5 percent.
// RL4: Outside that window force full duty when low, zero when high.
// RL5: Output-ok only while output is within plus or minus 10 percent.
// RL6: Output-ok low in soft start, evaluated once soft start ends.
// RL7: After soft start, latch shutdown when output exceeds 115 percent.
// RL8: In shutdown high side low, low side high, output-ok low.
// RL9: Leave shutdown only on enable toggle, reset, or code release and reapply.
// RL10: Overcurrent when switch drop exceeds the limit resistor drop.
// RL11: Ignore overcurrent 300 ns after high-side turn-on; sample while on.
// RL12: Overcurrent cuts high side, turns low side on until next cycle.
// RL13: Start soft start only out of reset, enabled, with valid code.
// RL14: Soft start lasts 2048 switching cycles, then loop takes over.
// RL15: Clearing shutdown restarts from the beginning of soft start.
// RL16: Reset holds all state and keeps both gates off.
// RL17: Shutdown overrides current cut and fast overrides; low side stays on.
`timescale 1ns/1ps
module bgc_ctrl #(
  parameter int RAMP_W    = 8,
  parameter int SENSE_W   = 12,
  parameter int SS_CYCLES = bgc_pkg::SS_CYCLES
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               regulator_enable_in,
  input  wire logic [4:0]         voltage_code_in,
  input  wire logic               current_limit_sense,
  input  wire logic [SENSE_W-1:0] senseCode,
  input  wire logic [RAMP_W-1:0]  errAmpCode,
  input  wire logic [3:0]         regAddr,
  input  wire logic [31:0]        regWdata,
  input  wire logic               regWr,
  input  wire logic               regRd,
  output logic      [31:0]        regRdata,
  output logic                    hsGate,
  output logic                    lsGate,
  output logic                    outputOk,
  output logic                    irq
);

  localparam int SS_W = $clog2(SS_CYCLES);
  localparam int TW   = SENSE_W + 8;
  localparam logic [SS_W-1:0] SS_LAST = SS_W'(SS_CYCLES - 1);
  localparam logic [4:0]      BLANK_C = 5'(bgc_pkg::BLANK_CYC);

  // Pin synchronisers: stage one is read only by stage two
  logic [6:0] pinMeta_r;
  logic [6:0] pinSync_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinMeta_r <= 7'h00;
      pinSync_r <= 7'h00;
    end else begin
      pinMeta_r <= {current_limit_sense, voltage_code_in, regulator_enable_in};
      pinSync_r <= pinMeta_r;
    end
  end

  wire       enS       = pinSync_r[0];
  wire [4:0] codeS     = pinSync_r[5:1];
  wire       ilimS     = pinSync_r[6];
  wire       codeValid = codeS != bgc_pkg::CODE_RELEASED;
  wire       startOk   = enS & codeValid;

  logic prevEn_r;
  logic prevValid_r;
  wire  enToggle     = enS ^ prevEn_r;
  wire  codeReapplied = codeValid & ~prevValid_r;

  // Window thresholds as percent products, no division needed
  wire [SENSE_W-1:0] refCode = bgc_pkg::REF_BASE +
                               12'(12'(codeS) * bgc_pkg::REF_STEP);
  wire [TW-1:0] senseX100 = TW'(senseCode) * TW'(bgc_pkg::PCT_FULL);

  function automatic logic [TW-1:0] thr(input logic [SENSE_W-1:0] r, input int pct);
    thr = TW'(r) * TW'(pct);
  endfunction : thr

  wire fastLo = senseX100 < thr(refCode, bgc_pkg::PCT_FULL - bgc_pkg::WIN_FAST_PCT); // RL3
  wire fastHi = senseX100 > thr(refCode, bgc_pkg::PCT_FULL + bgc_pkg::WIN_FAST_PCT); // RL3
  wire goodWin =
    !(senseX100 < thr(refCode, bgc_pkg::PCT_FULL - bgc_pkg::WIN_GOOD_PCT)) &&
    !(senseX100 > thr(refCode, bgc_pkg::PCT_FULL + bgc_pkg::WIN_GOOD_PCT));   // RL5
  wire ovTrip = senseX100 > thr(refCode, bgc_pkg::OVP_PCT);                   // RL7

  // Free-running ramp; its wrap marks each switching cycle
  logic [RAMP_W-1:0] rampCnt_r;
  wire               cycleStart = rampCnt_r == '0;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rampCnt_r <= '0;
    end else begin
      rampCnt_r <= rampCnt_r + RAMP_W'(1);
    end
  end

  // Sequencer
  bgc_pkg::bgc_state_t state_r;
  bgc_pkg::bgc_state_t state_nxt;
  logic [SS_W-1:0]     ssCnt_r;
  wire                 ssDone = cycleStart && (ssCnt_r == SS_LAST);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bgc_pkg::ST_IDLE: begin
        if (startOk) state_nxt = bgc_pkg::ST_SOFT; // RL13
      end
      bgc_pkg::ST_SOFT: begin
        if (!startOk) state_nxt = bgc_pkg::ST_IDLE;
        else if (ssDone) state_nxt = bgc_pkg::ST_RUN; // RL14
      end
      bgc_pkg::ST_RUN: begin
        if (ovTrip) state_nxt = bgc_pkg::ST_OVP; // RL7
        else if (!startOk) state_nxt = bgc_pkg::ST_IDLE;
      end
      bgc_pkg::ST_OVP: begin
        // Idle then re-enters soft start from count zero
        if (enToggle || codeReapplied) state_nxt = bgc_pkg::ST_IDLE; // RL9 RL15
      end
      default: state_nxt = bgc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r     <= bgc_pkg::ST_IDLE; // RL16
      prevEn_r    <= 1'b0;
      prevValid_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      prevEn_r    <= enS;
      prevValid_r <= codeValid;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || state_r != bgc_pkg::ST_SOFT) begin
      ssCnt_r <= '0; // RL15
    end else if (cycleStart) begin
      ssCnt_r <= ssCnt_r + SS_W'(1); // RL14
    end
  end

  // Soft start caps the error level with a rising limit
  wire [RAMP_W-1:0] ssLevel  = ssCnt_r[SS_W-1 -: RAMP_W];
  wire              inSoft   = state_r == bgc_pkg::ST_SOFT;
  wire              inRun    = state_r == bgc_pkg::ST_RUN;
  wire              inOvp    = state_r == bgc_pkg::ST_OVP;
  wire              inIdle   = state_r == bgc_pkg::ST_IDLE;
  wire [RAMP_W-1:0] ctlLevel = (inSoft && ssLevel < errAmpCode) ? ssLevel : errAmpCode;
  wire              pwmOn    = ctlLevel > rampCnt_r; // RL2

  // Control register
  logic ctrlFastEn_r;
  wire  fastAct   = inRun & ctrlFastEn_r;
  wire  forceHigh = fastAct & fastLo;  // RL4
  wire  forceLow  = fastAct & fastHi;  // RL4

  // Current limit with blanking
  logic       ocLatch_r;
  logic [4:0] blankCnt_r;
  wire        blankDone = blankCnt_r == BLANK_C;
  wire        ocSample  = hsGate & blankDone & ilimS; // RL10 RL11
  always_ff @(posedge ref_clk) begin
    if (reset || !hsGate) begin
      blankCnt_r <= 5'h00; // RL11
    end else if (!blankDone) begin
      blankCnt_r <= blankCnt_r + 5'h01;
    end
  end

  // New detection wins over the cycle-start release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ocLatch_r <= 1'b0;
    end else begin
      ocLatch_r <= ocSample | (ocLatch_r & ~cycleStart); // RL12
    end
  end

  // Shutdown outranks current cut and fast overrides
  wire runDemand = forceHigh ? 1'b1 : (forceLow ? 1'b0 : pwmOn);
  wire hsDemand  = ~inOvp & ~ocLatch_r & ~ocSample & runDemand; // RL12 RL17 RL8
  wire gateEn    = ~(state_r == bgc_pkg::ST_IDLE);              // RL16

  bgc_pkg::bgc_gate_t gate;
  bgc_deadtime #(
    .DEAD (bgc_pkg::DEAD_CYC)
  ) bgc_deadtime_inst (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .enable   (gateEn),
    .hsDemand (hsDemand),
    .gate     (gate)
  );
  assign hsGate = gate.hs;
  assign lsGate = gate.ls;

  // Output ok: only in run, so low in soft start and in shutdown
  wire okNxt = inRun & goodWin & ~ovTrip; // RL5 RL6 RL8
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      outputOk <= 1'b0;
    end else begin
      outputOk <= okNxt;
    end
  end

  // Events and interrupt
  bgc_pkg::bgc_event_t ev;
  assign ev.overvoltage_shutdown    = inRun & ovTrip;
  assign ev.ocp    = ocSample & ~ocLatch_r;
  assign ev.fast   = inRun & (fastLo | fastHi); // RL3
  assign ev.pgLost = outputOk & ~okNxt;

  wire addrStat  = regAddr == bgc_pkg::ADDR_STATUS;
  wire addrInt   = regAddr == bgc_pkg::ADDR_INT_STAT;
  wire addrMask  = regAddr == bgc_pkg::ADDR_INT_MASK;
  wire addrCtrl  = regAddr == bgc_pkg::ADDR_CTRL;
  wire intRdClr  = regRd & addrInt;

  logic [3:0] intStat_r;
  logic [3:0] intMask_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      intStat_r    <= 4'h0;
      intMask_r    <= 4'h0;
      ctrlFastEn_r <= bgc_pkg::CTRL_FAST_RST;
      irq          <= 1'b0;
    end else begin
      // A new event in the clearing read stays set
      intStat_r <= (intRdClr ? 4'h0 : intStat_r) | ev;
      irq       <= |(intStat_r & intMask_r);
      if (regWr && addrMask) intMask_r <= regWdata[3:0];
      if (regWr && addrCtrl) ctrlFastEn_r <= regWdata[bgc_pkg::CTRL_FAST_EN];
    end
  end

  wire [31:0] statusWord = {23'h000000, codeValid, fastHi, fastLo, ocLatch_r,
                            outputOk, state_r};
  wire [31:0] rdMux = addrStat ? statusWord :
                      addrInt  ? {28'h0000000, intStat_r} :
                      addrMask ? {28'h0000000, intMask_r} :
                      addrCtrl ? {31'h00000000, ctrlFastEn_r} : 32'h00000000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdata <= 32'h00000000;
    end else begin
      regRdata <= regRd ? rdMux : 32'h00000000;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence ovpHeld;
    (state_r == bgc_pkg::ST_OVP) [*3];
  endsequence

  sequence fastHighHeld;
    (forceHigh && !ocLatch_r && !ocSample && !inOvp) [*3];
  endsequence

  ovp_gates_a: assert property (ovpHeld |-> lsGate && !hsGate && !outputOk) // RL8
    else $error("shutdown gates wrong");

  ovp_entry_a: assert property (inRun && ovTrip |=> state_r == bgc_pkg::ST_OVP) // RL7
    else $error("shutdown not entered");

  ovp_latch_a: assert property (inOvp && !enToggle && !codeReapplied |=> inOvp) // RL9
    else $error("shutdown left without cause");

  soft_ok_a: assert property (inSoft |=> !outputOk) // RL6
    else $error("output ok during soft start");

  ok_window_a: assert property (outputOk |-> $past(goodWin) && $past(inRun)) // RL5
    else $error("output ok outside window");

  soft_len_a: assert property ($rose(inRun) |-> $past(inSoft) && $past(ssCnt_r) == SS_LAST) // RL14
    else $error("soft start length wrong");

  oc_blank_a: assert property ($rose(ocLatch_r) |-> $past(hsGate && blankCnt_r == BLANK_C)) // RL11
    else $error("overcurrent sampled in blanking");

  oc_cut_a: assert property (ocLatch_r |=> !hsGate) // RL12
    else $error("high side on after overcurrent");

  fast_max_a: assert property (fastHighHeld |-> hsGate) // RL4
    else $error("fast low excursion not at full duty");

  start_hold_a: assert property (inIdle && !startOk |=> inIdle) // RL13
    else $error("started without enable and code");

  // Sequencing, cut-off and register framing guards
  sequence idleHeld;
    inIdle [*2];
  endsequence

  sequence fastLowHeld;
    forceLow [*2];
  endsequence

  idle_gates_a: assert property (idleHeld |-> !hsGate && !lsGate) // RL16
    else $error("gate on while idle");

  fast_zero_a: assert property (fastLowHeld |-> !hsGate) // RL4
    else $error("fast high excursion not at zero duty");

  ovp_clear_a: assert property (inOvp && (enToggle || codeReapplied) |=> inIdle) // RL9 RL15
    else $error("shutdown not cleared");

  soft_restart_a: assert property ($rose(inSoft) |-> ssCnt_r == SS_W'(0)) // RL15
    else $error("soft start not from zero");

  ss_step_a: assert property (inSoft && startOk && cycleStart && !ssDone |=> // RL14
                              ssCnt_r == $past(ssCnt_r) + SS_W'(1))
    else $error("soft start count skipped");

  oc_hold_a: assert property (ocLatch_r && !cycleStart |=> ocLatch_r) // RL12
    else $error("overcurrent released early");

  ok_good_a: assert property (inRun && goodWin && !ovTrip |=> outputOk) // RL5 RL6
    else $error("output ok missing in window");

  int_set_a: assert property ((|ev) |=> (intStat_r & $past(ev)) == $past(ev))
    else $error("event not held in status");

  irq_level_a: assert property (irq == |($past(intStat_r) & $past(intMask_r)))
    else $error("interrupt level wrong");

  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h00000000)
    else $error("read data outside its cycle");

endmodule : bgc_ctrl

/* File: dv/bgc_switch_model.sv */
/*
  Model of the external high-side and low-side switches and the drop comparator.
  Assumes gate commands on ref_clk; the bench sets overload to force a high drop.
*/
`timescale 1ns/1ps
module bgc_switch_model (
  input  wire logic ref_clk,
  input  wire logic hsGate,
  input  wire logic lsGate,
  input  wire logic overload,
  output logic      current_limit_sense
);
  // An open switch shows no drop; the comparator settles within one clock
  always_ff @(posedge ref_clk) begin
    current_limit_sense <= hsGate & ~lsGate & overload;
  end
endmodule : bgc_switch_model

/* File: dv/bgc_ctrl_tb_top.sv */
/*
  Self-checking bench for bgc_ctrl: reset, soft start, ramp duty, fast
  overrides, output-ok window, current limit, shutdown latch, registers.
  Assumes bgc_pkg and the switch model; soft start shortened to 256.
*/
`timescale 1ns/1ps
module bgc_ctrl_tb_top;
  localparam int SS = 256;
  logic        ref_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        enable   = 1'b0;
  logic [11:0] sense    = 12'h200;
  logic [7:0]  errAmp   = 8'h80;
  logic [3:0]  regAddr  = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic        regWr    = 1'b0;
  logic        regRd    = 1'b0;
  logic        overload = 1'b0;
  logic [4:0]  vcode    = 5'h00;
  logic        prevHs   = 1'b0;
  logic        prevLs   = 1'b0;
  logic [31:0] regRdata;
  logic        hsGate;
  logic        lsGate;
  logic        outputOk;
  logic        irq;
  logic        limitSense;
  logic [31:0] d;
  int          hsN;
  int          lsN;
  int          miscompares = 0;
  int          nCompared   = 0;

  always #10 ref_clk = ~ref_clk;

  bgc_ctrl #(.SS_CYCLES(SS)) bgc_ctrl_inst (
    .ref_clk(ref_clk), .reset(reset), .regulator_enable_in(enable),
    .voltage_code_in(vcode), .current_limit_sense(limitSense), .senseCode(sense),
    .errAmpCode(errAmp), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .hsGate(hsGate), .lsGate(lsGate),
    .outputOk(outputOk), .irq(irq));

  bgc_switch_model bgc_switch_model_inst (
    .ref_clk(ref_clk), .hsGate(hsGate), .lsGate(lsGate), .overload(overload),
    .current_limit_sense(limitSense));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic inRange(input int n, input int lo, input int hi);
    check(32'(n), (n >= lo && n <= hi) ? 32'(n) : 32'(lo));
  endtask : inRange

  // One gate may not rise in the cycle after the other was on; read mid-cycle
  always @(negedge ref_clk) begin
    check({31'h0, (lsGate & prevHs) | (hsGate & prevLs)}, 32'h0);
    prevHs <= hsGate;
    prevLs <= lsGate;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr    <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [3:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd   <= 1'b0;
    #1;
    d = regRdata;
  endtask : regRead

  // Gate on-time over one full switching period
  task automatic measure();
    hsN = 0;
    lsN = 0;
    repeat (256) begin
      tick(1);
      hsN += int'(hsGate === 1'b1);
      lsN += int'(lsGate === 1'b1);
    end
  endtask : measure

  task automatic t_reset();
    tick(5);
    check({28'h0, hsGate, lsGate, outputOk, irq}, 32'h0);
    reset <= 1'b0;
    measure();
    check(32'(hsN + lsN), 32'h0);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d & 32'hf, 32'h1);
    regRead(bgc_pkg::ADDR_CTRL);
    check(d, 32'h1);
    regRead(4'h2);
    check(d, 32'h0);
  endtask : t_reset

  task automatic t_soft();
    int n;
    n = 0;
    enable <= 1'b1;
    while (outputOk !== 1'b1 && n < SS * 256 + 600) begin
      tick(1);
      n++;
    end
    inRange(n, SS * 256 - 256, SS * 256 + 8);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d, 32'h114);
  endtask : t_soft

  task automatic t_pwm();
    logic [7:0] lv [2] = '{8'h40, 8'hc0};
    foreach (lv[i]) begin
      errAmp <= lv[i];
      measure();
      measure();
      inRange(hsN, int'(lv[i]) - 2, int'(lv[i]));
      inRange(lsN, 254 - int'(lv[i]), 256 - int'(lv[i]));
    end
  endtask : t_pwm

  task automatic t_fast();
    regWrite(bgc_pkg::ADDR_INT_MASK, 32'h0);
    sense <= 12'h1e0;
    tick(4);
    measure();
    inRange(hsN, 254, 256);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d, 32'h154);
    regWrite(bgc_pkg::ADDR_CTRL, 32'h0);
    measure();
    measure();
    inRange(hsN, 8'hbe, 8'hc0);
    regWrite(bgc_pkg::ADDR_CTRL, 32'h1);
    sense <= 12'h221;
    tick(4);
    measure();
    check(32'(hsN), 32'h0);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d, 32'h194);
    check({31'h0, irq}, 32'h0);
    sense <= 12'h200;
    tick(4);
    regWrite(bgc_pkg::ADDR_INT_MASK, 32'hf);
    tick(2);
    check({31'h0, irq}, 32'h1);
    regRead(bgc_pkg::ADDR_INT_STAT);
    check(d, 32'h4);
    tick(2);
    check({31'h0, irq}, 32'h0);
  endtask : t_fast

  task automatic t_ok();
    sense <= 12'h23a;
    tick(4);
    check({31'h0, outputOk}, 32'h0);
    sense <= 12'h200;
    tick(4);
    check({31'h0, outputOk}, 32'h1);
    regRead(bgc_pkg::ADDR_INT_STAT);
    check(d, 32'hc);
    vcode <= 5'h01;
    tick(6);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d, 32'h154);
    vcode <= 5'h00;
    tick(6);
    regRead(bgc_pkg::ADDR_INT_STAT);
    check(d, 32'h4);
  endtask : t_ok

  task automatic t_ocp();
    errAmp   <= 8'h80;
    overload <= 1'b1;
    measure();
    measure();
    inRange(hsN, bgc_pkg::BLANK_CYC, bgc_pkg::BLANK_CYC + 5);
    inRange(lsN, 250 - bgc_pkg::BLANK_CYC, 256 - bgc_pkg::BLANK_CYC);
    regRead(bgc_pkg::ADDR_INT_STAT);
    check(d, 32'h2);
    overload <= 1'b0;
    measure();
    measure();
    inRange(hsN, 8'h7e, 8'h80);
  endtask : t_ocp

  task automatic t_ovp();
    overload <= 1'b1;
    errAmp   <= 8'hff;
    sense    <= 12'h258;
    tick(8);
    measure();
    check({hsN[15:0], lsN[15:0]}, 32'h0000_0100);
    check({31'h0, outputOk}, 32'h0);
    sense <= 12'h200;
    measure();
    check({hsN[15:0], lsN[15:0]}, 32'h0000_0100);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d & 32'hf, 32'h8);
    regRead(bgc_pkg::ADDR_INT_STAT);
    check(d & 32'h1, 32'h1);
    overload <= 1'b0;
    vcode    <= 5'h1f;
    tick(6);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d & 32'hf, 32'h8);
    enable   <= 1'b0;
    tick(6);
    enable   <= 1'b1;
    tick(6);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d & 32'h1f, 32'h1);
    vcode    <= 5'h00;
    tick(6);
    regRead(bgc_pkg::ADDR_STATUS);
    check(d & 32'h1f, 32'h2);
  endtask : t_ovp

  task automatic print_verdict();
    $display("compared %0d, miscompares %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  // Whole run is near 70k cycles; allow some margin
  initial begin
    #(90000 * 20);
    miscompares++;
    print_verdict();
  end

  initial begin
    t_reset();
    t_soft();
    t_pwm();
    t_fast();
    t_ok();
    t_ocp();
    t_ovp();
    print_verdict();
  end
endmodule : bgc_ctrl_tb_top
